/* design/isl_fifo.sv */
`timescale 1ns/1ns
module isl_fifo #(
    parameter int WIDTH = isl_pkg::BYTE_W,
    parameter int DEPTH = isl_pkg::TX_DEPTH
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             resetn,
    // Filling side
    input  wire logic             push_valid,
    input  wire logic [WIDTH-1:0] push_data,
    output logic                  push_ready,
    // Draining side
    isl_pop_if.src                pop
);

    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wptr;
        logic [AW-1:0]               rptr;
        logic [CW-1:0]               count;
        logic                        not_full;
        logic                        not_empty;
    } isl_fifo_state_t;

    localparam isl_fifo_state_t FIFO_RESET = '{mem: '0, wptr: '0, rptr: '0, count: '0,
                                               not_full: 1'b1, not_empty: 1'b0};

    isl_fifo_state_t q;
    isl_fifo_state_t d;
    logic            do_push;
    logic            do_pop;

    // Full and empty are kept as flops so both ready and valid leave from registers.
    always_comb begin
        d       = q;
        do_push = push_valid && q.not_full;
        do_pop  = pop.ready && q.not_empty;
        if (do_push) begin
            d.mem[q.wptr] = push_data;
            d.wptr        = (q.wptr == AW'(DEPTH - 1)) ? '0 : q.wptr + AW'(1);
        end
        if (do_pop) begin
            d.rptr = (q.rptr == AW'(DEPTH - 1)) ? '0 : q.rptr + AW'(1);
        end
        if (do_push && !do_pop) begin
            d.count = q.count + CW'(1);
        end else if (do_pop && !do_push) begin
            d.count = q.count - CW'(1);
        end
        d.not_full  = (d.count != CW'(DEPTH));
        d.not_empty = (d.count != '0);
    end

    // State register.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= FIFO_RESET;
        end else begin
            q <= d;
        end
    end

    assign push_ready = q.not_full;
    assign pop.valid  = q.not_empty;
    assign pop.data   = q.mem[q.rptr];

endmodule : isl_fifo

/* design/isl_pkg.sv */
// Functional notes
// - Address hold: release bit cleared, flag at eighth fall.
// - Acknowledged read clears release bit, holds SCL.
// - Held byte drives chosen acknowledge value in ninth clock.
// - Transmit data write sets buffer full.
// - Shift eight bits out, capture master acknowledge.
// - Master not-acknowledge: stop holding, release bus.
// - Software buffer read clears buffer full.
// - Ten-bit high byte write: update flag, acknowledge, flag.
// - Update flag stretches SCL; address write releases it.
// - Low byte mismatch: flags set, buffer full and release untouched.
// - Ten-bit data byte: flag; stretch enable also holds.
// - Stretch enable holds SCL after every acknowledge.
// - Data hold clears release bit at eighth fall.
// - Provide acknowledge timing, direction, data/address status bits.
// - Start sets status; flag only if enabled.
// - Ten-bit address holds clear the release bit as seven-bit holds do; a ten-bit high byte write also holds SCL through the update flag.
// - Pull SCL only after sampling it already low.
// - Held SCL stays low until release bit set.
// - Transmit data changes on SCL falling edges.
// - Master acknowledge latched on ninth rising edge.
package isl_pkg;

    // Data path and buffering sizes.
    localparam int          BYTE_W       = 8;
    localparam int          TX_DEPTH     = 4;

    // Bit counts inside one byte on the bus.
    localparam logic [3:0]  BITS_IN_BYTE = 4'h8;
    localparam logic [3:0]  LAST_TX_BIT  = 4'h7;

    // Fixed upper five bits of a ten-bit header byte.
    localparam logic [4:0]  TEN_BIT_HDR  = 5'h1E;

    // Reset values of the software visible state.
    localparam logic [7:0]  ADDR_RESET   = 8'h00;
    localparam logic [7:0]  DATA_RESET   = 8'h00;
    localparam logic        RELEASE_RST  = 1'b1;

    // Bus engine states.
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX,
        ST_ACK_OUT,
        ST_TX,
        ST_ACK_IN
    } isl_state_t;

    // Which byte of a transfer the receiver expects next.
    typedef enum logic [1:0] {
        PH_ADDR,
        PH_ADDR_LO,
        PH_DATA
    } isl_phase_t;

endpackage : isl_pkg

/* design/isl_pop_if.sv */
`timescale 1ns/1ns
// Valid/ready stream between the transmit buffer and the bus engine.
interface isl_pop_if #(parameter int W = isl_pkg::BYTE_W);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : isl_pop_if

/* design/isl_slave.sv */
`timescale 1ns/1ns
module isl_slave (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,

    // Serial clock pin, open drain
    input  wire logic       scl_i,
    output logic            scl_o,
    output logic            scl_oe_n,

    // Serial data pin, open drain
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_n,

    // Configuration levels
    input  wire logic       ten_bit_mode,
    input  wire logic       address_hold_enable,
    input  wire logic       data_hold_enable,
    input  wire logic       clock_stretch_enable,
    input  wire logic       start_irq_enable,
    input  wire logic       ack_data_select,

    // Software strobes
    input  wire logic       release_set,
    input  wire logic       flag_clear,
    input  wire logic       addr_wr,
    input  wire logic [7:0] addr_wdata,
    input  wire logic       buf_rd,

    // Transmit data stream into the shift buffer
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            tx_ready,

    // Received data
    output logic [7:0]      rx_data,

    // Status
    output logic            clock_release_bit,
    output logic            port_interrupt_flag,
    output logic            buffer_full_flag,
    output logic            update_address_flag,
    output logic            ack_timing_status,
    output logic            ack_status_received,
    output logic            read_write_status,
    output logic            data_address_status,
    output logic            start_status,
    output logic            stop_status
);

    typedef struct packed {
        isl_pkg::isl_state_t state;
        isl_pkg::isl_phase_t phase;
        logic [3:0]          bit_cnt;
        logic [7:0]          shift;
        logic [7:0]          addr;
        logic [7:0]          rx_data;
        logic                scl_prev;
        logic                sda_prev;
        logic                release_bit;
        logic                intf;
        logic                bf;
        logic                ua;
        logic                ackt;
        logic                acks;
        logic                rw;
        logic                da;
        logic                start_s;
        logic                stop_s;
        logic                ack_go;
        logic                held;
        logic                ten_match;
        logic                loaded;
        logic                scl_oe_n;
        logic                sda_oe_n;
    } isl_slave_state_t;

    localparam isl_slave_state_t SLAVE_RESET = '{
        state: isl_pkg::ST_IDLE, phase: isl_pkg::PH_ADDR, bit_cnt: '0, shift: '0,
        addr: isl_pkg::ADDR_RESET, rx_data: isl_pkg::DATA_RESET,
        scl_prev: 1'b1, sda_prev: 1'b1, release_bit: isl_pkg::RELEASE_RST,
        intf: 1'b0, bf: 1'b0, ua: 1'b0, ackt: 1'b0, acks: 1'b0, rw: 1'b0, da: 1'b0,
        start_s: 1'b0, stop_s: 1'b0, ack_go: 1'b0, held: 1'b0, ten_match: 1'b0,
        loaded: 1'b0, scl_oe_n: 1'b1, sda_oe_n: 1'b1};

    isl_slave_state_t q;
    isl_slave_state_t d;

    logic       scl_s;
    logic       sda_s;
    logic       scl_rise;
    logic       scl_fall;
    logic       bus_start;
    logic       bus_stop;
    logic       push_fire;
    logic       byte_match;
    logic       hold_req;
    logic [7:0] rx_byte;

    isl_pop_if #(.W(isl_pkg::BYTE_W)) tx_pop ();

    // Both pins come from the other party's domain and are synchronised first.
    isl_sync #(.W(2)) u_sync (
        .clk    (clk),
        .resetn (resetn),
        .d      ({scl_i, sda_i}),
        .q_out  ({scl_s, sda_s})
    );

    // Transmit bytes queue here; a full queue pushes back on the writer.
    isl_fifo #(.WIDTH(isl_pkg::BYTE_W), .DEPTH(isl_pkg::TX_DEPTH)) u_tx_fifo (
        .clk        (clk),
        .resetn     (resetn),
        .push_valid (tx_valid),
        .push_data  (tx_data),
        .push_ready (tx_ready),
        .pop        (tx_pop.src)
    );

    // Edge and bus condition detection on the synchronised pins.
    assign scl_rise  = scl_s && !q.scl_prev;
    assign scl_fall  = !scl_s && q.scl_prev;
    assign bus_start = scl_s && q.scl_prev && q.sda_prev && !sda_s;
    assign bus_stop  = scl_s && q.scl_prev && !q.sda_prev && sda_s;
    assign push_fire = tx_valid && tx_ready;
    assign rx_byte   = q.shift;

    // The engine only takes a byte when it is waiting for one with SCL low.
    assign tx_pop.ready = (q.state == isl_pkg::ST_TX) && !q.loaded && !scl_s;

    // Address compare for the first byte after a start.
    always_comb begin
        if (ten_bit_mode) begin
            byte_match = (rx_byte[7:3] == isl_pkg::TEN_BIT_HDR) &&
                         (rx_byte[2:1] == q.addr[2:1]) &&
                         (!rx_byte[0] || q.ten_match);
        end else begin
            byte_match = (rx_byte[7:1] == q.addr[7:1]);
        end
    end

    // Next-state logic. Software actions are applied first so that a hardware
    // event in the same cycle overrides them and is never lost.
    always_comb begin
        d          = q;
        d.scl_prev = scl_s;
        d.sda_prev = sda_s;

        // Software side effects.
        if (flag_clear) begin
            d.intf = 1'b0;
        end
        if (buf_rd) begin
            d.bf = 1'b0;
        end
        if (release_set) begin
            d.release_bit = 1'b1;
        end
        if (addr_wr) begin
            d.addr = addr_wdata;
            d.ua   = 1'b0;
        end

        if (bus_start) begin
            // A start or repeated start restarts the receiver at any point.
            d.state    = isl_pkg::ST_RX;
            d.phase    = isl_pkg::PH_ADDR;
            d.bit_cnt  = '0;
            d.start_s  = 1'b1;
            d.stop_s   = 1'b0;
            d.sda_oe_n = 1'b1;
            d.ackt     = 1'b0;
            if (start_irq_enable) begin
                d.intf = 1'b1;
            end
        end else if (bus_stop) begin
            d.state     = isl_pkg::ST_IDLE;
            d.stop_s    = 1'b1;
            d.start_s   = 1'b0;
            d.ten_match = 1'b0;
            d.sda_oe_n  = 1'b1;
            d.ackt      = 1'b0;
        end else begin
            case (q.state)
                isl_pkg::ST_IDLE: begin
                    d.sda_oe_n = 1'b1;
                end

                isl_pkg::ST_RX: begin
                    if (scl_rise) begin
                        d.shift   = {q.shift[6:0], sda_s};
                        d.bit_cnt = q.bit_cnt + 4'h1;
                    end else if (scl_fall && q.bit_cnt == isl_pkg::BITS_IN_BYTE) begin
                        // Eighth falling edge: the whole byte is in.
                        d.held   = 1'b0;
                        d.ack_go = 1'b0;
                        d.ackt   = 1'b1;
                        d.state  = isl_pkg::ST_ACK_OUT;
                        case (q.phase)
                            isl_pkg::PH_ADDR: begin
                                if (byte_match) begin
                                    d.rw      = rx_byte[0];
                                    d.da      = 1'b0;
                                    d.rx_data = rx_byte;
                                    d.bf      = 1'b1;
                                    d.ack_go  = 1'b1;
                                    if (ten_bit_mode && !rx_byte[0]) begin
                                        d.ua   = 1'b1;
                                        d.intf = 1'b1;
                                    end
                                    if (address_hold_enable) begin
                                        d.release_bit = 1'b0;
                                        d.intf        = 1'b1;
                                        d.held        = 1'b1;
                                    end
                                end else begin
                                    d.state     = isl_pkg::ST_IDLE;
                                    d.ackt      = 1'b0;
                                    d.ten_match = 1'b0;
                                end
                            end
                            isl_pkg::PH_ADDR_LO: begin
                                // Flag and update request are raised either way.
                                d.ua   = 1'b1;
                                d.intf = 1'b1;
                                if (rx_byte == q.addr) begin
                                    d.ten_match = 1'b1;
                                    d.da        = 1'b0;
                                    d.rx_data   = rx_byte;
                                    d.bf        = 1'b1;
                                    d.ack_go    = 1'b1;
                                    if (address_hold_enable) begin
                                        d.release_bit = 1'b0;
                                        d.held        = 1'b1;
                                    end
                                end
                            end
                            default: begin
                                d.rx_data = rx_byte;
                                d.da      = 1'b1;
                                d.bf      = 1'b1;
                                d.ack_go  = 1'b1;
                                if (data_hold_enable) begin
                                    d.release_bit = 1'b0;
                                    d.intf        = 1'b1;
                                    d.held        = 1'b1;
                                end
                            end
                        endcase
                    end
                end

                isl_pkg::ST_ACK_OUT: begin
                    // The answer may change only while SCL is low; a held byte
                    // follows the software choice through the whole low phase, the hold included.
                    if (!scl_s && !scl_fall) begin
                        d.sda_oe_n = q.held ? ack_data_select : !q.ack_go;
                    end
                    if (scl_fall) begin
                        // Ninth falling edge ends the acknowledge sequence.
                        d.ackt     = 1'b0;
                        d.sda_oe_n = 1'b1;
                        d.bit_cnt  = '0;
                        if (q.sda_oe_n) begin
                            d.state = isl_pkg::ST_IDLE;
                        end else begin
                            d.intf = 1'b1;
                            if (q.rw) begin
                                d.state       = isl_pkg::ST_TX;
                                d.loaded      = 1'b0;
                                d.release_bit = 1'b0;
                            end else begin
                                d.state = isl_pkg::ST_RX;
                                if (q.phase == isl_pkg::PH_ADDR && ten_bit_mode) begin
                                    d.phase = isl_pkg::PH_ADDR_LO;
                                end else begin
                                    d.phase = isl_pkg::PH_DATA;
                                end
                                if (clock_stretch_enable) begin
                                    d.release_bit = 1'b0;
                                end
                            end
                        end
                    end
                end

                isl_pkg::ST_TX: begin
                    if (!q.loaded) begin
                        if (tx_pop.valid && !scl_s) begin
                            // First bit goes out while SCL is still low.
                            d.shift    = tx_pop.data;
                            d.loaded   = 1'b1;
                            d.sda_oe_n = tx_pop.data[7];
                            d.bf       = push_fire;
                        end
                    end else if (scl_fall) begin
                        d.bit_cnt = q.bit_cnt + 4'h1;
                        if (q.bit_cnt == isl_pkg::LAST_TX_BIT) begin
                            d.state    = isl_pkg::ST_ACK_IN;
                            d.sda_oe_n = 1'b1;
                        end else begin
                            d.shift    = {q.shift[6:0], 1'b0};
                            d.sda_oe_n = q.shift[6];
                        end
                    end
                end

                isl_pkg::ST_ACK_IN: begin
                    d.sda_oe_n = 1'b1;
                    if (scl_rise) begin
                        d.acks = sda_s;
                    end else if (scl_fall) begin
                        d.intf    = 1'b1;
                        d.bit_cnt = '0;
                        if (!q.acks) begin
                            d.state       = isl_pkg::ST_TX;
                            d.loaded      = 1'b0;
                            d.release_bit = 1'b0;
                        end else begin
                            d.state = isl_pkg::ST_IDLE;
                        end
                    end
                end

                default: begin
                    d.state = isl_pkg::ST_IDLE;
                end
            endcase
        end

        // A transmit byte written by software marks the buffer full.
        if (push_fire) begin
            d.bf = 1'b1;
        end

        // Stretch request: cleared release bit, pending address update, or a
        // transmitter still waiting for its byte. The update flag holds only
        // once the acknowledge is over, so software never races the answer.
        // A loaded byte keeps SCL one more cycle so its first bit sets up.
        hold_req = (d.ua && d.state != isl_pkg::ST_ACK_OUT) ||
                   ((d.state != isl_pkg::ST_IDLE) &&
                    (!d.release_bit ||
                     (d.state == isl_pkg::ST_TX && !(d.loaded && q.loaded))));
        // Grab SCL only once the master has already pulled it low, so the
        // high time it produced is never shortened.
        d.scl_oe_n = !(hold_req && (!q.scl_oe_n || !scl_s));
    end

    // State register.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= SLAVE_RESET;
        end else begin
            q <= d;
        end
    end

    // Pins only ever pull low; the enable decides whether they float.
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;

    // Outputs straight from the state register.
    assign scl_oe_n            = q.scl_oe_n;
    assign sda_oe_n            = q.sda_oe_n;
    assign rx_data             = q.rx_data;
    assign clock_release_bit   = q.release_bit;
    assign port_interrupt_flag = q.intf;
    assign buffer_full_flag    = q.bf;
    assign update_address_flag = q.ua;
    assign ack_timing_status   = q.ackt;
    assign ack_status_received = q.acks;
    assign read_write_status   = q.rw;
    assign data_address_status = q.da;
    assign start_status        = q.start_s;
    assign stop_status         = q.stop_s;

endmodule : isl_slave

/* design/isl_sync.sv */
`timescale 1ns/1ns
module isl_sync #(
    parameter int W = 2
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         resetn,
    // Asynchronous levels in, synchronised levels out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q_out
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } isl_sync_state_t;

    isl_sync_state_t q;
    isl_sync_state_t dn;

    // Idle bus lines are high, so the stages reset high to avoid a false edge.
    always_comb begin
        dn    = q;
        dn.s1 = d;
        dn.s2 = q.s1;
    end

    // Only the second stage is visible outside.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= '1;
        end else begin
            q <= dn;
        end
    end

    assign q_out = q.s2;

endmodule : isl_sync

/* verification/isl_master.sv */
`timescale 1ns/1ns
// Bus master model; it only pulls lines low, and SCL stands still between frames.
module isl_master (
    // Resolved lines and own pulls
    input  wire logic scl, sda,
    output logic      scl_m = 1'b1, sda_m = 1'b1
);
    int bad = 0;
    task automatic start();
        sda_m = 0;
        #200 scl_m = 0;
        #50;
    endtask : start
    task automatic stop();
        sda_m = 0;
        #200 scl_m = 1;
        #150 sda_m = 1;
        #200;
    endtask : stop
    // A slave stretch only lengthens the low phase, and the wait is bounded.
    task automatic bit_x(input logic b, output logic r);
        int n;
        n = 0;
        sda_m = b;
        #200 scl_m = 1;
        while (!scl && n < 5000) #10 n++;
        if (n == 5000) bad++;
        #150 r = sda;
        scl_m = 0;
        #50;
    endtask : bit_x
    task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
        for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
        bit_x(a, k);
    endtask : xfer
endmodule : isl_master

/* verification/isl_monitor.sv */
`timescale 1ns/1ns
// Pin and status timing checks; ports grouped to keep the file short.
module isl_monitor (
    // Clock, reset and pins
    input wire logic clk, resetn, scl_i, scl_o, scl_oe_n, sda_o, sda_oe_n,
    // Software side and status
    input wire logic addr_wr, tx_valid, tx_ready,
    input wire logic clock_release_bit, buffer_full_flag, update_address_flag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // A hardware drop of the release bit starts every hold except one made by the update flag alone.
    sequence s_drop;
        $fell(clock_release_bit);
    endsequence
    AST_SCL_OD: assert property (scl_o == 1'b0) else $error("scl high");
    AST_SDA_OD: assert property (sda_o == 1'b0) else $error("sda high");
    AST_BF_PUSH: assert property (tx_valid && tx_ready |=> buffer_full_flag)
        else $error("push not flagged");
    AST_UA_CLR: assert property (addr_wr && !scl_oe_n |=> !update_address_flag)
        else $error("update flag kept");
    AST_UA_FREE: assert property (addr_wr && update_address_flag |-> ##[1:4] scl_oe_n)
        else $error("scl not freed");
    AST_PULL: assert property ($fell(scl_oe_n) |-> !clock_release_bit || update_address_flag)
        else $error("scl pulled unasked");
    AST_HOLD: assert property (s_drop |-> ##[0:12] !scl_oe_n)
        else $error("hold missing");
    AST_SDA_EDGE: assert property ($changed(sda_oe_n) |-> !scl_i)
        else $error("sda moved, scl high");
endmodule : isl_monitor
bind isl_slave isl_monitor isl_monitor_i (.clk, .resetn, .scl_i, .scl_o, .scl_oe_n, .sda_o,
    .sda_oe_n, .addr_wr, .tx_valid, .tx_ready, .clock_release_bit, .buffer_full_flag,
    .update_address_flag);

/* verification/tb.sv */
`timescale 1ns/1ns
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb;
    logic        clk = 0, resetn = 0, ten = 0, ah = 1, str = 0, ads = 0, tv = 0;
    logic        rs = 0, aw = 0, fc = 0, br = 0, scl_m, sda_m, scl_oe_n, sda_oe_n, ak;
    logic        rel, irq, full, upd, tim, ackr, rw, st, da, sp, dh = 0;
    logic [7:0]  awd = 0, nxt = 0, td = 0, rxd, q, eq [4];
    logic [5:0]  snap;
    logic [31:0] seed = 32'hFD7AF6F5;
    int          bad_count = 0, checked = 0, cd = 0, n;
    wire         scl = scl_m & scl_oe_n;
    wire         sda = sda_m & sda_oe_n;
    always #25 clk = ~clk;
    isl_slave isl_slave_i (.clk, .resetn, .scl_i(scl), .scl_o(), .scl_oe_n, .sda_i(sda),
        .sda_o(), .sda_oe_n, .ten_bit_mode(ten), .address_hold_enable(ah),
        .data_hold_enable(dh), .clock_stretch_enable(str), .start_irq_enable(seed[3]),
        .ack_data_select(ads), .release_set(rs), .flag_clear(fc), .addr_wr(aw),
        .addr_wdata(awd), .buf_rd(br), .tx_valid(tv), .tx_data(td), .tx_ready(),
        .rx_data(rxd), .clock_release_bit(rel), .port_interrupt_flag(irq),
        .buffer_full_flag(full), .update_address_flag(upd), .ack_timing_status(tim),
        .ack_status_received(ackr), .read_write_status(rw), .data_address_status(da),
        .start_status(st), .stop_status(sp));
    isl_master isl_master_i (.scl, .sda, .scl_m, .sda_m);
    // Software answers each hold once, then lets the strobes fall.
    always @(negedge clk) begin
        if (cd != 0) begin
            cd <= cd - 1;
            {rs, aw, fc, br} <= 4'h0;
        end else if (resetn && !scl_oe_n) begin
            cd <= 6;
            snap <= {rel, irq, full, rw, tim, upd};
            {rs, aw, fc, br} <= {!upd, upd, 2'b11};
            awd <= nxt;
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    function automatic logic [7:0] hi10(input logic [9:0] a);
        return {isl_pkg::TEN_BIT_HDR, a[9:8], 1'b0};
    endfunction : hi10
    task automatic final_report();
        bad_count = bad_count + isl_master_i.bad;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    // One byte on the bus; w waits, bounded, for software to answer the hold.
    task automatic x(input logic [7:0] d, input logic a, input logic w);
        isl_master_i.xfer(d, a, q, ak);
        n = 0;
        do @(negedge clk); while (w && cd == 0 && ++n < 400);
        if (n == 400) begin
            bad_count++;
            final_report();
        end
    endtask : x
    initial begin
        repeat (8) @(negedge clk);
        resetn = 1;
        nxt = 8'h54;
        awd <= nxt;
        aw <= 1;
        @(negedge clk);
        aw <= 0;
        for (int k = 0; k < 2; k++) begin
            ads = (k == 0);
            isl_master_i.start();
            `CHK("start", 1'b1, st)
            x(8'h55, 1, 0);
            `CHK("addr_ack", ads, ak)
            `CHK("addr_hold", 6'h1E, snap)
            for (int b = 0; b < 4 * k; b++) begin
                seed = xs(seed);
                eq[b] = seed[7:0];
                td <= seed[7:0];
                tv <= 1;
                @(negedge clk);
            end
            tv <= 0;
            for (int b = 0; b < 4 * k; b++) begin
                x(8'hFF, b == 3, 0);
                `CHK("tx_byte", eq[b], q)
                `CHK("ack_seen", b == 3, ackr)
            end
            repeat (12) @(negedge clk);
            `CHK("freed", 1'b1, scl_oe_n)
            isl_master_i.stop();
            `CHK("stop", 1'b1, sp)
            $display("read test %0d done", k);
        end
        ten = 1;
        ah = 0;
        nxt = 8'hB5;
        isl_master_i.start();
        x(hi10(10'h2B5), 1, 1);
        `CHK("hi_ack", 1'b0, ak)
        `CHK("hi_hold", 6'h39, snap)
        `CHK("hi_da", 1'b0, da)
        nxt = hi10(10'h2B5);
        x(8'hB5, 1, 1);
        `CHK("lo_hold", 6'h39, snap)
        dh = 1;
        seed = xs(seed);
        x(seed[7:0], 1, 0);
        `CHK("dhold", 6'h1A, snap)
        `CHK("dh_ack", 1'b0, ak)
        `CHK("data_da", 1'b1, da)
        dh = 0;
        str = 1;
        seed = xs(seed);
        x(seed[7:0], 1, 1);
        `CHK("data_hold", 6'h18, snap)
        `CHK("data", seed[7:0], rxd)
        isl_master_i.stop();
        `CHK("stop10", 1'b1, sp)
        $display("ten-bit test done");
        final_report();
    end
endmodule : tb
